// ---- hdl/sdw_pkg.sv ----
// Purpose: Shared constants for the supervisory reset and dual watchdog block.
// Assumes: 250 MHz system clock; durations count a 1 us internal tick.
// Notes:   Factory choices are module parameters; rail, order and duration defaults live here.
package sdw_pkg;
	localparam int CLK_NS        = 4;
	localparam int TICK_NS       = 1000;
	localparam int TICK_CYC      = TICK_NS / CLK_NS;
	localparam int MAN_GLITCH_NS  = 100;
	localparam int MAN_GLITCH_CYC = MAN_GLITCH_NS / CLK_NS;
	localparam int CLR_S         = 10;
	localparam int SEQ_GAP_MS    = 2;

	localparam logic [31:0] CLR_US_DEF     = 32'(CLR_S * 1000000);
	localparam logic [31:0] SEQ_GAP_US_DEF = 32'(SEQ_GAP_MS * 1000);
	localparam logic [31:0] RP_US_DEF      = 32'h0003_0D40;
	localparam logic [31:0] RP1_US_DEF     = 32'h0003_0D40;
	localparam logic [31:0] RP2_US_DEF     = 32'h0000_2710;
	localparam logic [31:0] POFF_US_DEF    = 32'h0001_86A0;
	localparam logic [1:0][31:0] WD1_OPT_DEF = {32'h0018_6A00, 32'h0001_86A0};
	localparam logic [7:0][31:0] WD2_OPT_DEF = {
		32'h07A1_2000, 32'h03D0_9000, 32'h01E8_4800, 32'h00F4_2400,
		32'h007A_1200, 32'h003D_0900, 32'h001E_8480, 32'h000F_4240};

	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;
	localparam logic [11:0] CFG_OFS  = 12'h008;
	localparam int CTRL_MAN_BIT = 0;
	localparam int STAT_RST_BIT = 0;
	localparam int STAT_CAU_BIT = 1;
	localparam int STAT_RPN_BIT = 2;
	localparam int STAT_CPN_BIT = 3;
	localparam int STAT_MAN_BIT = 4;
	localparam int STAT_WD1_BIT = 5;
	localparam int STAT_BCK_BIT = 6;
	localparam int STAT_LDO_BIT = 7;
	localparam int STAT_ST_LSB  = 8;
	localparam int CFG_MON_LSB  = 0;
	localparam int CFG_UV_BIT   = 2;
	localparam int CFG_WD1_BIT  = 3;
	localparam int CFG_WD2_LSB  = 4;
	localparam int CFG_SEQ_LSB  = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	localparam logic [1:0] MON_BUCK = 2'h0;
	localparam logic [1:0] MON_LDO  = 2'h1;
	localparam logic [1:0] MON_SUPPLY = 2'h2;
	localparam logic [1:0] SEQ_LDO_FIRST = 2'h0;
	localparam logic [1:0] SEQ_ALL       = 2'h3;

	typedef enum logic [2:0] {
		S_RUN  = 3'h0,
		S_HOLD = 3'h1,
		S_RP   = 3'h3,
		S_RP2  = 3'h2,
		S_POFF = 3'h6,
		S_SEQ  = 3'h7,
		S_RP1  = 3'h5
	} sdw_state_e;
endpackage : sdw_pkg

// ---- hdl/sdw_supervisor.sv ----
// Purpose: Reset supervisor with undervoltage, manual reset and two watchdogs.
// Assumes: Inputs are synchronous to sys_clk_i; rail comparators are external.
// Notes:   Open-drain pins are value, enable and readback; APB has no waits.
// How it works
// [RQ1] Reset pin is pulled low while the monitored rail is under threshold.
// [RQ2] After rail recovery or watchdog expiry, reset stays low one timeout.
// [RQ3] Monitored rail and threshold are fixed parameters, not run-time settings.
// [RQ4] Supply rail below lockout asserts reset at once when threshold is lower.
// [RQ5] Manual reset low asserts reset; release starts the reset timeout.
// [RQ6] Manual reset lows of 100 ns or less are filtered out.
// [RQ7] Any edge on the short kick restarts the short watchdog.
// [RQ8] Short watchdog expiry asserts reset followed by the reset timeout.
// [RQ9] Undervoltage reset clears both watchdogs; they wait for reset release.
// [RQ10] Lock select low: floating short kick disables the short watchdog.
// [RQ11] Lock select high: short watchdog always runs, float ignored.
// [RQ12] Short watchdog timeout is one of two factory values.
// [RQ13] Long watchdog runs in parallel; any edge of its kick restarts it.
// [RQ14] Long expiry: reset pulse, regulators off, ordered restart, reset pulse.
// [RQ15] Long watchdog timeout is one of eight factory values.
// [RQ16] Cause pin is pulled low only for a long watchdog reset.
// [RQ17] Cause pin releases 10 s after reset goes high.
// [RQ18] Other resets within 10 s of release leave the cause pin unchanged.
// [RQ19] Processor toggles both kicks inside their timeouts.
// [RQ20] Processor reads the cause pin before the clear interval ends.
// [RQ21] Processor classifies cause from the pin plus a memory signature check.
// [RQ22] Regulator restarts in sequence are 2 ms apart.
// [RQ23] Order select: 00 LDO first, 01/10 buck first, 11 together.
// [RQ24] Durations are parameters counted on an internal 1 us tick.
`timescale 1ns/1ns
module sdw_supervisor #(
	parameter logic [1:0]        MON_SEL       = sdw_pkg::MON_LDO,
	parameter logic              TH_BELOW_LOCK = 1'b0,
	parameter logic [1:0]        SEQ_SEL       = sdw_pkg::SEQ_LDO_FIRST,
	parameter logic              WD1_SEL       = 1'b0,
	parameter logic [1:0][31:0]  WD1_OPT_US    = sdw_pkg::WD1_OPT_DEF,
	parameter logic [2:0]        WD2_SEL       = 3'h0,
	parameter logic [7:0][31:0]  WD2_OPT_US    = sdw_pkg::WD2_OPT_DEF,
	parameter logic [31:0]       RP_US         = sdw_pkg::RP_US_DEF,
	parameter logic [31:0]       RP1_US        = sdw_pkg::RP1_US_DEF,
	parameter logic [31:0]       RP2_US        = sdw_pkg::RP2_US_DEF,
	parameter logic [31:0]       POFF_US       = sdw_pkg::POFF_US_DEF,
	parameter logic [31:0]       SEQ_GAP_US    = sdw_pkg::SEQ_GAP_US_DEF,
	parameter logic [31:0]       CLR_US        = sdw_pkg::CLR_US_DEF
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        buck_output_rail_low_i,
	input  wire logic        ldo_output_rail_low_i,
	input  wire logic        analog_supply_in_low_i,
	input  wire logic        undervoltage_lockout_i,
	input  wire logic        manual_reset_in_n_i,
	input  wire logic        short_wd_kick_i,
	input  wire logic        short_wd_kick_float_i,
	input  wire logic        short_wd_lock_sel_i,
	input  wire logic        long_wd_kick_i,
	input  wire logic        reset_out_n_i,
	output logic             reset_out_n_o,
	output logic             reset_out_n_oe_o,
	input  wire logic        reset_cause_out_i,
	output logic             reset_cause_out_o,
	output logic             reset_cause_out_oe_o,
	output logic             buck_enable_o,
	output logic             ldo_enable_o
);
	import sdw_pkg::*;

	localparam logic [7:0]  TICK_LAST   = 8'(TICK_CYC - 1);
	localparam logic [5:0]  MAN_CNT_LAST = 6'(MAN_GLITCH_CYC);
	localparam logic [31:0] WD1_LIM     = WD1_OPT_US[WD1_SEL]; // RQ12
	localparam logic [31:0] WD2_LIM     = WD2_OPT_US[WD2_SEL]; // RQ15

	typedef struct packed {
		sdw_state_e  state;
		logic [7:0]  tick;
		logic [31:0] tmr;
		logic [31:0] wd1;
		logic [31:0] wd2;
		logic [31:0] clr;
		logic        clr_act;
		logic        cause;
		logic        buck_en;
		logic        ldo_en;
		logic        ctrl_man;
		logic [5:0]  man_cnt;
		logic        man_low;
		logic        k1;
		logic        k2;
		logic [31:0] prdata;
		logic        pslverr;
	} sdw_st_s;

	localparam sdw_st_s ST_RST = '{state: S_RP, buck_en: 1'b1, ldo_en: 1'b1, default: '0};

	sdw_st_s     st;
	sdw_st_s     next_st;
	logic        tick;
	logic        uv;
	logic        lvl_rst;
	logic        run;
	logic        k1_edge;
	logic        k2_edge;
	logic        wd1_en;
	logic        wd1_exp;
	logic        wd2_exp;
	logic [31:0] lim;
	logic        tdone;
	logic        setup;
	logic        wr_acc;
	logic [31:0] stat_word;
	logic [31:0] cfg_word;

	assign tick = (st.tick == TICK_LAST); // RQ24
	// The rail choice is a build-time constant, so only the selected rail's comparator is used, plus the lockout input in supply mode when TH_BELOW_LOCK is set.
	assign uv = (MON_SEL == MON_BUCK) ? buck_output_rail_low_i : // RQ3
		(MON_SEL == MON_LDO) ? ldo_output_rail_low_i :
		(analog_supply_in_low_i || (TH_BELOW_LOCK && undervoltage_lockout_i)); // RQ4
	assign lvl_rst = uv || st.man_low || st.ctrl_man;
	assign run     = (st.state == S_RUN);
	assign k1_edge = (short_wd_kick_i != st.k1); // RQ7
	assign k2_edge = (long_wd_kick_i != st.k2); // RQ13
	assign wd1_en  = short_wd_lock_sel_i || !short_wd_kick_float_i; // RQ10 RQ11
	assign wd1_exp = wd1_en && !k1_edge && (st.wd1 >= WD1_LIM); // RQ8
	assign wd2_exp = !k2_edge && (st.wd2 >= WD2_LIM);
	assign tdone   = tick && ((st.tmr + 32'h1) >= lim);
	assign setup   = psel_i && !penable_i;
	assign wr_acc  = psel_i && penable_i && pwrite_i;

	always_comb begin
		case (st.state)
			S_RP:    lim = RP_US;
			S_RP1:   lim = RP1_US;
			S_RP2:   lim = RP2_US;
			S_POFF:  lim = POFF_US;
			S_SEQ:   lim = SEQ_GAP_US;
			default: lim = 32'h0000_0001;
		endcase
	end

	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[STAT_RST_BIT] = !run;
		stat_word[STAT_CAU_BIT] = st.cause;
		stat_word[STAT_RPN_BIT] = reset_out_n_i;
		stat_word[STAT_CPN_BIT] = reset_cause_out_i;
		stat_word[STAT_MAN_BIT] = st.man_low;
		stat_word[STAT_WD1_BIT] = wd1_en;
		stat_word[STAT_BCK_BIT] = st.buck_en;
		stat_word[STAT_LDO_BIT] = st.ldo_en;
		stat_word[STAT_ST_LSB +: 3] = st.state;
		cfg_word = 32'h0000_0000;
		cfg_word[CFG_MON_LSB +: 2] = MON_SEL;
		cfg_word[CFG_UV_BIT]       = TH_BELOW_LOCK;
		cfg_word[CFG_WD1_BIT]      = WD1_SEL;
		cfg_word[CFG_WD2_LSB +: 3] = WD2_SEL;
		cfg_word[CFG_SEQ_LSB +: 2] = SEQ_SEL;
	end

	always_comb begin
		next_st      = st;
		next_st.tick = tick ? 8'h00 : st.tick + 8'h01;
		next_st.k1   = short_wd_kick_i;
		next_st.k2   = long_wd_kick_i;
		next_st.tmr  = tick ? st.tmr + 32'h1 : st.tmr;

		// Low must persist past the glitch window before it counts.
		if (manual_reset_in_n_i) begin
			next_st.man_cnt = 6'h00;
			next_st.man_low = 1'b0;
		end else if (st.man_cnt == MAN_CNT_LAST) begin
			next_st.man_low = 1'b1; // RQ6
		end else begin
			next_st.man_cnt = st.man_cnt + 6'h01;
		end

		// Counters clear one cycle after reset is asserted and sit at zero while it stays asserted.
		if (!run || !wd1_en || k1_edge) begin
			next_st.wd1 = 32'h0; // RQ7 RQ9 RQ10
		end else if (tick && !wd1_exp) begin
			next_st.wd1 = st.wd1 + 32'h1;
		end
		if (!run || k2_edge) begin
			next_st.wd2 = 32'h0; // RQ9 RQ13
		end else if (tick && !wd2_exp) begin
			next_st.wd2 = st.wd2 + 32'h1;
		end

		// Clear comes first so a same-cycle long expiry still sets the flag.
		if (st.clr_act && tick) begin
			if ((st.clr + 32'h1) >= CLR_US) begin
				next_st.clr_act = 1'b0;
				next_st.cause   = 1'b0; // RQ17
			end else begin
				next_st.clr = st.clr + 32'h1;
			end
		end

		case (st.state)
			S_RUN: begin
				if (lvl_rst) begin
					next_st.state = S_HOLD; // RQ1 RQ5
				end else if (wd2_exp) begin
					next_st.state   = S_RP2; // RQ14
					next_st.cause   = 1'b1; // RQ16
					next_st.clr_act = 1'b0;
				end else if (wd1_exp) begin
					next_st.state = S_RP; // RQ8 RQ18
				end
			end
			S_HOLD: begin
				if (!lvl_rst) begin
					next_st.state = S_RP; // RQ2 RQ5
				end
			end
			S_RP: begin
				if (lvl_rst) begin
					next_st.state = S_HOLD;
				end else if (tdone) begin
					next_st.state = S_RUN; // RQ2
				end
			end
			S_RP2: begin
				if (tdone) begin
					next_st.state   = S_POFF; // RQ14
					next_st.buck_en = 1'b0;
					next_st.ldo_en  = 1'b0;
				end
			end
			S_POFF: begin
				if (tdone) begin
					next_st.state   = S_SEQ;
					next_st.ldo_en  = (SEQ_SEL == SEQ_LDO_FIRST) || (SEQ_SEL == SEQ_ALL); // RQ23
					next_st.buck_en = (SEQ_SEL != SEQ_LDO_FIRST);
				end
			end
			S_SEQ: begin
				if (SEQ_SEL == SEQ_ALL || tdone) begin
					next_st.state   = S_RP1; // RQ22
					next_st.buck_en = 1'b1;
					next_st.ldo_en  = 1'b1;
				end
			end
			S_RP1: begin
				if (lvl_rst) begin
					next_st.state = S_HOLD;
				end else if (tdone) begin
					next_st.state = S_RUN; // RQ14
				end
			end
			default: begin
				next_st.state = S_HOLD;
			end
		endcase

		if (next_st.state != st.state) begin
			next_st.tmr = 32'h0;
		end
		if (!run && next_st.state == S_RUN) begin
			next_st.clr_act = 1'b1; // RQ17
			next_st.clr     = 32'h0;
		end

		// Register bus: decode in setup, write at the access edge.
		if (setup) begin
			next_st.pslverr = 1'b0;
			if (paddr_i == CTRL_OFS) begin
				next_st.prdata = {31'h0, st.ctrl_man};
			end else if (paddr_i == STAT_OFS) begin
				next_st.prdata = stat_word;
			end else if (paddr_i == CFG_OFS) begin
				next_st.prdata = cfg_word;
			end else begin
				next_st.prdata  = 32'h0;
				next_st.pslverr = 1'b1;
			end
		end
		if (wr_acc && paddr_i == CTRL_OFS) begin
			next_st.ctrl_man = pwdata_i[CTRL_MAN_BIT];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st <= ST_RST;
		end else begin
			st <= next_st;
		end
	end

	assign prdata_o             = st.prdata;
	assign pready_o             = 1'b1;
	assign pslverr_o            = st.pslverr;
	assign reset_out_n_o        = 1'b0;
	assign reset_out_n_oe_o     = !run;
	assign reset_cause_out_o    = 1'b0;
	assign reset_cause_out_oe_o = st.cause;
	assign buck_enable_o        = st.buck_en;
	assign ldo_enable_o         = st.ldo_en;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	property p_uv_rst;
		uv && (run || st.state == S_RP) |=> reset_out_n_oe_o ##1 reset_out_n_oe_o;
	endproperty
	a_uv_rst: assert property (p_uv_rst) else $error("Undervoltage did not hold reset."); // RQ1

	property p_rp_len;
		$fell(reset_out_n_oe_o) && $past(st.state) == S_RP |-> $past(st.tmr) == RP_US - 32'h1;
	endproperty
	a_rp_len: assert property (p_rp_len) else $error("Reset timeout length wrong."); // RQ2

	property p_man_glitch;
		$rose(st.man_low) |->
			$past(st.man_cnt) == MAN_CNT_LAST && !$past(manual_reset_in_n_i);
	endproperty
	a_man_glitch: assert property (p_man_glitch) else $error("Manual reset filter wrong."); // RQ6

	property p_man_hold;
		st.man_low && run |=> st.state == S_HOLD ##1 reset_out_n_oe_o;
	endproperty
	a_man_hold: assert property (p_man_hold) else $error("Manual reset ignored."); // RQ5

	property p_kick1;
		run && k1_edge |=> st.wd1 == 32'h0;
	endproperty
	a_kick1: assert property (p_kick1) else $error("Short kick did not restart."); // RQ7

	property p_wd1_exp;
		run && wd1_exp && !lvl_rst && !wd2_exp |=> st.state == S_RP && reset_out_n_oe_o;
	endproperty
	a_wd1_exp: assert property (p_wd1_exp) else $error("Short expiry missed."); // RQ8

	property p_wd_clr;
		!run |=> st.wd1 == 32'h0 && st.wd2 == 32'h0;
	endproperty
	a_wd_clr: assert property (p_wd_clr) else $error("Watchdog counted in reset."); // RQ9

	property p_wd1_off;
		!short_wd_lock_sel_i && short_wd_kick_float_i |=> st.wd1 == 32'h0;
	endproperty
	a_wd1_off: assert property (p_wd1_off) else $error("Floating kick not disabling."); // RQ10

	property p_poff;
		st.state == S_POFF |-> !buck_enable_o && !ldo_enable_o && reset_out_n_oe_o;
	endproperty
	a_poff: assert property (p_poff) else $error("Regulators on during power off."); // RQ14

	property p_cause_set;
		run && wd2_exp && !lvl_rst |=> reset_cause_out_oe_o && st.state == S_RP2;
	endproperty
	a_cause_set: assert property (p_cause_set) else $error("Long expiry cause not set."); // RQ16

	property p_cause_clr;
		$fell(st.cause) |-> $past(st.clr) == CLR_US - 32'h1;
	endproperty
	a_cause_clr: assert property (p_cause_clr) else $error("Cause cleared at wrong time."); // RQ17

	property p_kick2;
		run && k2_edge |=> st.wd2 == 32'h0;
	endproperty
	a_kick2: assert property (p_kick2) else $error("Long kick did not restart."); // RQ13

	property p_seq_gap;
		st.state == S_RP1 && $past(st.state) == S_SEQ && SEQ_SEL != SEQ_ALL |->
			$past(st.tmr) == SEQ_GAP_US - 32'h1;
	endproperty
	a_seq_gap: assert property (p_seq_gap) else $error("Regulator gap wrong."); // RQ22
endmodule : sdw_supervisor

// ---- tb/sdw_host_model.sv ----
// Purpose: Host processor model that kicks both watchdogs and reads the cause pin.
// Assumes: Kicks stop while the reset pin is low, as a processor held in reset would.
// Notes:   The bench stops a kick stream to provoke a watchdog expiry.
`timescale 1ns/1ns
module sdw_host_model #(
	parameter int SHORT_HALF = 500,
	parameter int LONG_HALF  = 2500
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic reset_pin_i,
	input  wire logic cause_pin_i,
	input  wire logic short_en_i,
	input  wire logic long_en_i,
	output logic      short_wd_kick_o,
	output logic      long_wd_kick_o,
	output logic      cause_low_seen_o
);
	int s_cnt;
	int l_cnt;
	int up_cnt;

	always_ff @(posedge clk_i) begin
		if (rst_i || !reset_pin_i) begin
			s_cnt <= 0;
			l_cnt <= 0;
			up_cnt <= 0;
			if (rst_i) begin
				short_wd_kick_o <= 1'b0;
				long_wd_kick_o <= 1'b0;
				cause_low_seen_o <= 1'b0;
			end
		end else begin
			s_cnt <= (s_cnt == SHORT_HALF - 1) ? 0 : s_cnt + 1;
			l_cnt <= (l_cnt == LONG_HALF - 1) ? 0 : l_cnt + 1;
			if (short_en_i && s_cnt == SHORT_HALF - 1) begin
				short_wd_kick_o <= ~short_wd_kick_o;
			end
			if (long_en_i && l_cnt == LONG_HALF - 1) begin
				long_wd_kick_o <= ~long_wd_kick_o;
			end
			if (up_cnt < 16) begin
				up_cnt <= up_cnt + 1;
			end
			if (up_cnt == 15) begin
				cause_low_seen_o <= !cause_pin_i;
			end
		end
	end
endmodule : sdw_host_model

// ---- tb/tb_supervisor_dual_watchdog_reset.sv ----
// Purpose: Self-checking bench for the supervisory reset and dual watchdog block.
// Assumes: Durations are shortened to a few 1 us ticks of 250 cycles.
// Notes:   Open-drain pins resolve through modelled pull-ups.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb_supervisor_dual_watchdog_reset;
	import sdw_pkg::*;
	localparam int T = TICK_CYC;
	localparam logic [31:0] RP = 32'h4, RP1 = 32'h3, RP2 = 32'h2, POFF = 32'h3;
	localparam logic [31:0] GAP = 32'h2, CLR = 32'h28;
	localparam logic [31:0] EXP_CFG = (32'(MON_LDO) << CFG_MON_LSB)
		| (32'(SEQ_LDO_FIRST) << CFG_SEQ_LSB);
	localparam logic [31:0] EXP_STAT = (32'h1 << STAT_CAU_BIT) | (32'h1 << STAT_RPN_BIT)
		| (32'h1 << STAT_WD1_BIT) | (32'h1 << STAT_BCK_BIT) | (32'h1 << STAT_LDO_BIT);
	logic        sys_clk_i, rst_i, psel, pen, pwr, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rnd, rd;
	logic        buck_low, ldo_low, sup_low, lock_out, man_n, flt, lock, s_en, l_en;
	logic        s_kick, l_kick, seen, rst_oe, rst_o, cau_oe, cau_o, buck_en, ldo_en;
	wire         rst_pin = rst_oe ? rst_o : 1'b1;
	wire         cau_pin = cau_oe ? cau_o : 1'b1;
	int          n_mismatch, checks, n;

	sdw_supervisor #(.MON_SEL(MON_LDO), .SEQ_SEL(SEQ_LDO_FIRST), .WD1_OPT_US({32'h10, 32'h8}),
		.WD2_OPT_US({8{32'h18}}), .RP_US(RP), .RP1_US(RP1), .RP2_US(RP2), .POFF_US(POFF),
		.SEQ_GAP_US(GAP), .CLR_US(CLR)) u_dut (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .buck_output_rail_low_i(buck_low),
		.ldo_output_rail_low_i(ldo_low), .analog_supply_in_low_i(sup_low),
		.undervoltage_lockout_i(lock_out), .manual_reset_in_n_i(man_n), .short_wd_kick_i(s_kick),
		.short_wd_kick_float_i(flt), .short_wd_lock_sel_i(lock), .long_wd_kick_i(l_kick),
		.reset_out_n_i(rst_pin), .reset_out_n_o(rst_o), .reset_out_n_oe_o(rst_oe),
		.reset_cause_out_i(cau_pin), .reset_cause_out_o(cau_o),
		.reset_cause_out_oe_o(cau_oe), .buck_enable_o(buck_en), .ldo_enable_o(ldo_en));

	sdw_host_model u_host (.clk_i(sys_clk_i), .rst_i(rst_i), .reset_pin_i(rst_pin),
		.cause_pin_i(cau_pin), .short_en_i(s_en), .long_en_i(l_en),
		.short_wd_kick_o(s_kick), .long_wd_kick_o(l_kick), .cause_low_seen_o(seen));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	task automatic tally_and_finish;
		if (n_mismatch == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish

	// Waits for a watched output to reach a level; cnt is one less than the cycles spent waiting.
	task automatic wait_sig(input int w, input logic v, input int lim, output int cnt);
		logic s;
		for (cnt = 0; cnt <= lim; cnt++) begin
			@(posedge sys_clk_i);
			#1;
			case (w)
				0: s = rst_oe;
				1: s = buck_en;
				2: s = ldo_en;
				default: s = cau_oe;
			endcase
			if (s === v) break;
		end
		if (cnt > lim) begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask : wait_sig

	task automatic hold_chk(input logic [31:0] us);
		wait_sig(0, 1'b0, (us + 2) * T, n);
		`CHK("hold", 1'b1, n >= (us - 1) * T && n <= (us + 1) * T + 4)
	endtask : hold_chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge sys_clk_i);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_i);
		pen <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge sys_clk_i);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		er = pslverr;
		if (k == 16) begin
			n_mismatch++;
			tally_and_finish();
		end
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	initial begin
		{rst_i, man_n, s_en, l_en} = 4'hF;
		{psel, pen, pwr, paddr, pwdata, buck_low, ldo_low, sup_low, lock_out, flt, lock} = '0;
		{n_mismatch, checks, rnd} = {32'h0, 32'h0, 32'h9528C915};
		repeat (6) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		hold_chk(RP);
		apb(1'b1, CFG_OFS, rnd);
		apb(1'b0, CFG_OFS, 32'h0);
		`CHK("cfg", EXP_CFG, rd)
		apb(1'b0, 12'h00C, 32'h0);
		`CHK("unmapped", 1'b1, er)
		`CHK("unmapped_rd", 32'h0, rd)
		@(posedge sys_clk_i);
		{buck_low, sup_low, lock_out} <= 3'b111;
		repeat (20) @(posedge sys_clk_i);
		#1 `CHK("other_rail", 1'b0, rst_oe)
		@(posedge sys_clk_i);
		{buck_low, ldo_low, sup_low, lock_out} <= 4'b0100;
		repeat (3) @(posedge sys_clk_i);
		#1 `CHK("uv_assert", 1'b1, rst_oe)
		`CHK("uv_pin", 1'b0, rst_pin)
		repeat (RP * T + T) @(posedge sys_clk_i);
		#1 `CHK("uv_stay", 1'b1, rst_oe)
		@(posedge sys_clk_i);
		ldo_low <= 1'b0;
		hold_chk(RP);
		rnd = lfsr(rnd);
		@(posedge sys_clk_i);
		man_n <= 1'b0;
		repeat (10 + rnd[3:0]) @(posedge sys_clk_i);
		man_n <= 1'b1;
		repeat (40) @(posedge sys_clk_i);
		#1 `CHK("man_glitch", 1'b0, rst_oe)
		@(posedge sys_clk_i);
		man_n <= 1'b0;
		wait_sig(0, 1'b1, 40, n);
		`CHK("man_filter", 1'b1, n >= MAN_GLITCH_CYC && n <= MAN_GLITCH_CYC + 2)
		repeat (200) @(posedge sys_clk_i);
		`CHK("man_low", 1'b1, rst_oe)
		man_n <= 1'b1;
		hold_chk(RP);
		@(posedge sys_clk_i);
		{s_en, flt} <= 2'b01;
		repeat (12 * T) @(posedge sys_clk_i);
		#1 `CHK("wd1_float_off", 1'b0, rst_oe)
		@(posedge sys_clk_i);
		lock <= 1'b1;
		wait_sig(0, 1'b1, 9 * T, n);
		hold_chk(RP);
		wait_sig(0, 1'b1, 10 * T, n);
		`CHK("wd1_time", 1'b1, n >= 7 * T && n <= 9 * T + 4)
		`CHK("wd1_cause", 1'b0, cau_oe)
		@(posedge sys_clk_i);
		{s_en, flt, lock} <= 3'b100;
		hold_chk(RP);
		@(posedge sys_clk_i);
		l_en <= 1'b0;
		wait_sig(0, 1'b1, 26 * T, n);
		@(posedge sys_clk_i);
		l_en <= 1'b1;
		wait_sig(1, 1'b0, (RP2 + 1) * T, n);
		`CHK("pre_off", 1'b1, n >= (RP2 - 1) * T && ldo_en === 1'b0)
		wait_sig(2, 1'b1, (POFF + 1) * T, n);
		`CHK("off_time", 1'b1, n >= (POFF - 1) * T && buck_en === 1'b0)
		wait_sig(1, 1'b1, (GAP + 1) * T, n);
		`CHK("seq_gap", 1'b1, n >= (GAP - 1) * T)
		`CHK("seq_rst", 1'b1, rst_oe)
		`CHK("wd2_cause", 1'b1, cau_oe)
		`CHK("cause_pin", 1'b0, cau_pin)
		hold_chk(RP1);
		repeat (40) @(posedge sys_clk_i);
		`CHK("host_seen", 1'b1, seen)
		ldo_low <= 1'b1;
		repeat (5) @(posedge sys_clk_i);
		ldo_low <= 1'b0;
		hold_chk(RP);
		`CHK("cause_kept", 1'b1, cau_oe)
		apb(1'b0, STAT_OFS, 32'h0);
		`CHK("stat", EXP_STAT, rd)
		wait_sig(3, 1'b0, (CLR + 2) * T, n);
		`CHK("clear_time", 1'b1, n >= (CLR - 1) * T && n <= (CLR + 1) * T + 4)
		apb(1'b1, CTRL_OFS, 32'h1 << CTRL_MAN_BIT);
		apb(1'b0, CTRL_OFS, 32'h0);
		`CHK("soft_rst", 1'b1, rst_oe)
		`CHK("ctrl", 32'h1 << CTRL_MAN_BIT, rd)
		apb(1'b1, CTRL_OFS, CTRL_RST);
		hold_chk(RP);
		`CHK("soft_cause", 1'b0, cau_oe)
		tally_and_finish();
	end
endmodule : tb_supervisor_dual_watchdog_reset
